//--- bmoc_pkg.sv
// package: addresses, field positions, timing and types for bmoc_top
// assumes a 25 MHz core clock shared by the serial slave and the control
package bmoc_pkg;
    // register addresses on the serial bus
    localparam logic [7:0] A_FREQ = 8'h33;
    localparam logic [7:0] A_UVR = 8'h45;
    localparam logic [7:0] A_SVOUT = 8'h7A;
    localparam logic [7:0] A_SIOUT = 8'h7B;
    localparam logic [7:0] A_CFG = 8'hA0;
    localparam logic [7:0] A_CAC = 8'hA9;
    localparam logic [7:0] A_CINT = 8'hAA;
    localparam logic [7:0] A_CLL = 8'hAD;
    // reset values and frequency code limit
    localparam logic [7:0] R_FREQ = 8'h00;
    localparam logic [7:0] R_UVR = 8'h00;
    localparam logic [7:0] R_CFG = 8'h00;
    localparam logic [7:0] R_COMP = 8'h00;
    localparam logic [7:0] FREQ_MAX = 8'h03;
    // field positions
    localparam int B_FORCED_CONTINUOUS_MODE = 0;
    localparam int B_RESTART = 3;
    localparam int B_UVF = 4;
    localparam int B_OCL = 7;
    // slave address, value arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h24;
    // timing
    localparam int CLK_NS = 40;
    localparam int UVD_STEP_NS = 1000;
    localparam int UVD_STEP_CYC = (UVD_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int HICCUP_MS = 56;
    localparam int HICCUP_CYC = HICCUP_MS * 1000000 / CLK_NS;
    // switching frequency per code, kHz
    localparam logic [10:0] FSW_KHZ [4] = '{11'h258, 11'h320, 11'h3E8, 11'h4B0};
    // power sequencing states
    typedef enum logic [4:0] {
        P_OFF = 5'h01, P_SS = 5'h02, P_RUN = 5'h04, P_LATCH = 5'h08, P_HICCUP = 5'h10
    } bmoc_pwr_e_t;
    // serial slave states
    typedef enum logic [4:0] {
        I_IDLE = 5'h01, I_RX = 5'h02, I_ACK = 5'h04, I_TX = 5'h08, I_MACK = 5'h10
    } bmoc_i2c_e_t;
    // inputs from outside the clock domain
    typedef struct packed {
        logic ls_on;
        logic valley_current_limit;
        logic uv;
        logic ss_done;
        logic en;
        logic sda;
        logic scl;
    } bmoc_in_t;
    // loop compensation selections
    typedef struct packed {
        logic [7:0] ac;
        logic [7:0] integ;
        logic [7:0] ll;
    } bmoc_comp_t;
endpackage

//--- bmoc_stage_model.sv
// file: behavioural power stage, analog comparators and current sense for bmoc_top
// assumes the bench clock; bench knobs change at falling edges only
`timescale 1ns/1ps
module bmoc_stage_model #(
    parameter int SS_CYC = 4000,
    parameter logic [7:0] I_START = 8'h28,
    parameter logic [7:0] I_END = 8'h50
) (
    // clock
    input wire logic i_clk,
    // bench knobs
    input wire logic i_heavy,
    input wire logic i_vout_low,
    // controls from the block
    input wire logic i_drv_off,
    input wire logic i_ss_run,
    input wire logic i_ls_hold,
    // comparators and sense
    output logic o_ss_done,
    output logic o_uv_cmp,
    output logic o_ocl_cmp,
    output logic o_ls_on,
    output logic [7:0] o_isense
);
    int ss_cnt = 0;
    int phase = 0;
    // ramp timer and switching phase, phase frozen while the clamp holds
    always @(posedge i_clk) begin
        ss_cnt <= i_ss_run ? ss_cnt + 1 : 0;
        if (!i_ls_hold) phase <= (phase + 1) % 20;
    end
    // ramp ends a fixed time after it starts
    assign o_ss_done = i_ss_run && (ss_cnt >= SS_CYC);
    assign o_uv_cmp = i_vout_low;
    assign o_ocl_cmp = i_heavy;
    // low side on for half the period, held on by the clamp, off when stopped
    assign o_ls_on = !i_drv_off && (i_ls_hold || phase < 10);
    // sense steady around both edges so late edge sampling sees one value
    assign o_isense = (phase >= 5 && phase < 15) ? I_END : I_START;
endmodule

//--- bmoc_top.sv
// file: mode, frequency, valley clamp and undervoltage control with serial slave
// assumes analog comparators and the power stage sit outside, bus, enable and comparator pins async, current sense and reset synchronous
//
// How it works
// - frequency code 00..03 decodes to 600, 800, 1000, 1200 kHz
// - forced-continuous bit chooses continuous or pulse-skipping operation
// - mode bit is sampled when enable rises and frozen while enabled
// - writes to the mode bit are acked but act only after enable toggles
// - low side held on, next high-side pulse blocked while valley current high
// - clamp action sets the overcurrent flag in the current status register
// - clamp never shuts down; only the undervoltage path does
// - undervoltage waits the programmed delay then stops the power stage
// - restart bit 0 latches both drivers off
// - latch clears only by supply reset or enable toggle
// - restart bit 1 sleeps 56 ms then restarts, without limit
// - valley clamp stays active during soft-start
// - undervoltage comparator ignored until soft-start completes
// - reported current is mean of low-side current over its on interval
// - clamp uses the comparator, never the telemetry converter
// - nonzero load line lowers target in proportion to load current
// - ac fields, integrator fields and load line come from three registers
// - undervoltage flag sets when the response delay starts
// - output recovering during the delay resets the delay timer
`timescale 1ns/1ps
module bmoc_top #(
    parameter int HICCUP_CYC = bmoc_pkg::HICCUP_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // serial bus, open drain data
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    // power stage and analog
    input wire logic i_en,
    input wire logic i_ss_done,
    input wire logic i_uv_cmp,
    input wire logic i_ocl_cmp,
    input wire logic i_ls_on,
    input wire logic [7:0] i_isense,
    // controls to the power stage and loop
    output logic [10:0] o_fsw_khz,
    output logic o_forced_continuous_mode,
    output logic o_ls_hold,
    output logic o_hs_block,
    output logic o_drv_off,
    output logic o_ss_run,
    output logic [7:0] o_iout_avg,
    output logic [15:0] o_droop,
    output bmoc_pkg::bmoc_comp_t o_comp
);
    typedef struct packed {
        bmoc_pkg::bmoc_in_t s1;
        bmoc_pkg::bmoc_in_t s2;
        bmoc_pkg::bmoc_in_t s3;
        bmoc_pkg::bmoc_i2c_e_t i2s;
        logic [7:0] sh;
        logic [3:0] bc;
        logic [1:0] idx;
        logic rw;
        logic [7:0] cmd;
        logic sda_oe;
        logic [7:0] freq;
        logic [7:0] uvr;
        logic [7:0] cfg;
        logic [7:0] sv;
        logic [7:0] si;
        bmoc_pkg::bmoc_comp_t comp;
        bmoc_pkg::bmoc_pwr_e_t ps;
        logic [20:0] cnt;
        logic forced_continuous_mode;
        logic [7:0] i0;
        logic [7:0] avg;
        logic [15:0] droop;
        logic [10:0] khz;
        logic ls_hold;
        logic hs_block;
        logic drv_off;
        logic ss_run;
    } bmoc_st_t;

    bmoc_st_t q_ff;
    bmoc_st_t nxt_q;
    logic scl, sda, en, uv, valley_current_limit, lson, conv;
    logic scl_r, scl_f, st_c, sp_c, ss_r;
    logic [20:0] dly;

    // edges seen between second and third sync stage
    assign scl = q_ff.s2.scl;
    assign sda = q_ff.s2.sda;
    assign en = q_ff.s2.en;
    assign uv = q_ff.s2.uv;
    assign valley_current_limit = q_ff.s2.valley_current_limit;
    assign lson = q_ff.s2.ls_on;
    assign scl_r = scl & ~q_ff.s3.scl;
    assign scl_f = ~scl & q_ff.s3.scl;
    assign st_c = scl & q_ff.s3.scl & ~sda & q_ff.s3.sda;
    assign sp_c = scl & q_ff.s3.scl & sda & ~q_ff.s3.sda;
    assign ss_r = q_ff.s2.ss_done & ~q_ff.s3.ss_done;
    assign conv = (q_ff.ps == bmoc_pkg::P_SS) | (q_ff.ps == bmoc_pkg::P_RUN);
    assign dly = 21'(q_ff.uvr[2:0] * bmoc_pkg::UVD_STEP_CYC);

    // register read mux
    function automatic logic [7:0] rd_data(input bmoc_st_t s);
        case (s.cmd)
            bmoc_pkg::A_FREQ: rd_data = s.freq;
            bmoc_pkg::A_UVR: rd_data = s.uvr;
            bmoc_pkg::A_SVOUT: rd_data = s.sv;
            bmoc_pkg::A_SIOUT: rd_data = s.si;
            bmoc_pkg::A_CFG: rd_data = s.cfg;
            bmoc_pkg::A_CAC: rd_data = s.comp.ac;
            bmoc_pkg::A_CINT: rd_data = s.comp.integ;
            bmoc_pkg::A_CLL: rd_data = s.comp.ll;
            default: rd_data = 8'h00;
        endcase
    endfunction

    // next state of slave, registers and sequencer
    always_comb begin
        logic ack;
        logic load;
        logic [7:0] rd;
        ack = 1'b0;
        load = 1'b0;
        rd = rd_data(q_ff);
        nxt_q = q_ff;
        nxt_q.s1 = '{i_ls_on, i_ocl_cmp, i_uv_cmp, i_ss_done, i_en, i_sda, i_scl};
        nxt_q.s2 = q_ff.s1;
        nxt_q.s3 = q_ff.s2;
        if (st_c) begin
            nxt_q.i2s = bmoc_pkg::I_RX;
            nxt_q.bc = 4'h0;
            nxt_q.idx = 2'h0;
            nxt_q.sda_oe = 1'b0;
        end else if (sp_c) begin
            nxt_q.i2s = bmoc_pkg::I_IDLE;
            nxt_q.sda_oe = 1'b0;
        end else begin
            case (q_ff.i2s)
                bmoc_pkg::I_IDLE: begin
                end
                bmoc_pkg::I_RX: begin
                    if (scl_r) begin
                        nxt_q.sh = {q_ff.sh[6:0], sda};
                        nxt_q.bc = q_ff.bc + 4'h1;
                    end else if (scl_f && q_ff.bc == 4'h8) begin
                        ack = 1'b1;
                        if (q_ff.idx == 2'h0) begin
                            ack = (q_ff.sh[7:1] == bmoc_pkg::DEV_ADDR);
                            nxt_q.rw = q_ff.sh[0];
                        end else if (q_ff.idx == 2'h1) begin
                            nxt_q.cmd = q_ff.sh;
                        end else begin
                            // writes; mode bit is stored but acts on next enable
                            case (q_ff.cmd)
                                bmoc_pkg::A_FREQ:
                                    if (q_ff.sh <= bmoc_pkg::FREQ_MAX) nxt_q.freq = q_ff.sh;
                                bmoc_pkg::A_UVR: nxt_q.uvr = q_ff.sh;
                                bmoc_pkg::A_CFG: nxt_q.cfg = q_ff.sh;
                                bmoc_pkg::A_CAC: nxt_q.comp.ac = q_ff.sh;
                                bmoc_pkg::A_CINT: nxt_q.comp.integ = q_ff.sh;
                                bmoc_pkg::A_CLL: nxt_q.comp.ll = q_ff.sh;
                                default: ;
                            endcase
                        end
                        nxt_q.idx = (q_ff.idx == 2'h2) ? 2'h2 : q_ff.idx + 2'h1;
                        nxt_q.i2s = ack ? bmoc_pkg::I_ACK : bmoc_pkg::I_IDLE;
                        nxt_q.sda_oe = ack;
                    end
                end
                bmoc_pkg::I_ACK: begin
                    if (scl_f) begin
                        if (q_ff.rw) begin
                            load = 1'b1;
                        end else begin
                            nxt_q.sda_oe = 1'b0;
                            nxt_q.bc = 4'h0;
                            nxt_q.i2s = bmoc_pkg::I_RX;
                        end
                    end
                end
                bmoc_pkg::I_TX: begin
                    if (scl_f) begin
                        if (q_ff.bc == 4'h8) begin
                            nxt_q.sda_oe = 1'b0;
                            nxt_q.i2s = bmoc_pkg::I_MACK;
                        end else begin
                            nxt_q.sda_oe = ~q_ff.sh[6];
                            nxt_q.sh = {q_ff.sh[6:0], 1'b0};
                            nxt_q.bc = q_ff.bc + 4'h1;
                        end
                    end
                end
                bmoc_pkg::I_MACK: begin
                    if (scl_r && sda) nxt_q.i2s = bmoc_pkg::I_IDLE;
                    else if (scl_f) load = 1'b1;
                end
                default: nxt_q.i2s = bmoc_pkg::I_IDLE;
            endcase
        end
        // byte load for read; status clears on read
        if (load) begin
            nxt_q.sh = rd;
            nxt_q.sda_oe = ~rd[7];
            nxt_q.bc = 4'h1;
            nxt_q.i2s = bmoc_pkg::I_TX;
            if (q_ff.cmd == bmoc_pkg::A_SIOUT) nxt_q.si = 8'h00;
            if (q_ff.cmd == bmoc_pkg::A_SVOUT) nxt_q.sv = 8'h00;
        end
        // power sequencer
        case (q_ff.ps)
            bmoc_pkg::P_OFF: begin
                nxt_q.cnt = '0;
                if (en && !q_ff.s3.en) begin
                    nxt_q.forced_continuous_mode = q_ff.cfg[bmoc_pkg::B_FORCED_CONTINUOUS_MODE];
                    nxt_q.ps = bmoc_pkg::P_SS;
                end
            end
            // undervoltage comparator ignored here
            bmoc_pkg::P_SS: if (ss_r) nxt_q.ps = bmoc_pkg::P_RUN;
            bmoc_pkg::P_RUN: begin // clamp never stops; only undervoltage does
                if (uv) begin
                    nxt_q.sv[bmoc_pkg::B_UVF] = 1'b1;
                    if (q_ff.cnt >= dly) begin
                        nxt_q.cnt = '0;
                        nxt_q.ps = q_ff.uvr[bmoc_pkg::B_RESTART]
                            ? bmoc_pkg::P_HICCUP : bmoc_pkg::P_LATCH;
                    end else begin
                        nxt_q.cnt = q_ff.cnt + 21'h1;
                    end
                end else begin
                    nxt_q.cnt = '0;
                end
            end
            bmoc_pkg::P_LATCH: nxt_q.cnt = '0;
            bmoc_pkg::P_HICCUP: begin
                // sleep then retry soft-start, no retry limit
                if (q_ff.cnt >= 21'(HICCUP_CYC - 1)) begin
                    nxt_q.cnt = '0;
                    nxt_q.ps = bmoc_pkg::P_SS;
                end else begin
                    nxt_q.cnt = q_ff.cnt + 21'h1;
                end
            end
            default: nxt_q.ps = bmoc_pkg::P_OFF;
        endcase
        // enable low clears latch and hiccup timer
        if (!en) begin
            nxt_q.ps = bmoc_pkg::P_OFF;
            nxt_q.cnt = '0;
        end
        // valley clamp from comparator, not telemetry
        nxt_q.ls_hold = conv & valley_current_limit;
        nxt_q.hs_block = conv & valley_current_limit;
        // flag set after clear so a new event wins
        if (conv && valley_current_limit && lson) nxt_q.si[bmoc_pkg::B_OCL] = 1'b1;
        // low-side mean: endpoints of linear ramp
        if (lson && !q_ff.s3.ls_on) nxt_q.i0 = i_isense;
        if (!lson && q_ff.s3.ls_on) nxt_q.avg = 8'(({1'b0, q_ff.i0} + {1'b0, i_isense}) >> 1);
        nxt_q.droop = 16'(q_ff.avg) * 16'(q_ff.comp.ll);
        nxt_q.khz = bmoc_pkg::FSW_KHZ[q_ff.freq[1:0]];
        nxt_q.drv_off = ~((nxt_q.ps == bmoc_pkg::P_SS) | (nxt_q.ps == bmoc_pkg::P_RUN));
        nxt_q.ss_run = (nxt_q.ps == bmoc_pkg::P_SS);
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            q_ff <= '0;
            q_ff.i2s <= bmoc_pkg::I_IDLE;
            q_ff.ps <= bmoc_pkg::P_OFF;
            q_ff.freq <= bmoc_pkg::R_FREQ;
            q_ff.uvr <= bmoc_pkg::R_UVR;
            q_ff.cfg <= bmoc_pkg::R_CFG;
            q_ff.comp <= {3{bmoc_pkg::R_COMP}};
            q_ff.khz <= bmoc_pkg::FSW_KHZ[0];
            q_ff.drv_off <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // outputs straight from state, except data output tied low
    assign o_sda_o = 1'b0;
    assign o_sda_oe = q_ff.sda_oe;
    assign o_fsw_khz = q_ff.khz;
    assign o_forced_continuous_mode = q_ff.forced_continuous_mode;
    assign o_ls_hold = q_ff.ls_hold;
    assign o_hs_block = q_ff.hs_block;
    assign o_drv_off = q_ff.drv_off;
    assign o_ss_run = q_ff.ss_run;
    assign o_iout_avg = q_ff.avg;
    assign o_droop = q_ff.droop;
    assign o_comp = q_ff.comp;

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence s_uv_now;
        q_ff.ps == bmoc_pkg::P_RUN && uv && nxt_q.ps != bmoc_pkg::P_OFF;
    endsequence
    sequence s_uv_latch0;
        s_uv_now and (q_ff.uvr[3:0] == 4'h0);
    endsequence

    a_fsw_decode: assert property (##1 o_fsw_khz == bmoc_pkg::FSW_KHZ[$past(q_ff.freq[1:0])])
        else $error("frequency decode wrong");
    a_mode_load: assert property (q_ff.ps == bmoc_pkg::P_OFF && en && !q_ff.s3.en
        |=> o_forced_continuous_mode == $past(q_ff.cfg[bmoc_pkg::B_FORCED_CONTINUOUS_MODE]))
        else $error("mode not sampled at enable");
    a_mode_frozen: assert property (en && q_ff.s3.en |=> $stable(o_forced_continuous_mode))
        else $error("mode changed while enabled");
    a_clamp_hold: assert property (conv && valley_current_limit |=> o_ls_hold && o_hs_block)
        else $error("valley clamp not applied");
    a_ocl_flag: assert property (conv && valley_current_limit && lson |=> q_ff.si[bmoc_pkg::B_OCL])
        else $error("overcurrent flag not set");
    a_no_ocl_stop: assert property (q_ff.ps == bmoc_pkg::P_RUN && !uv
        |=> q_ff.ps != bmoc_pkg::P_LATCH && q_ff.ps != bmoc_pkg::P_HICCUP)
        else $error("shutdown without undervoltage");
    a_uv_latch: assert property (s_uv_latch0 |=> q_ff.ps == bmoc_pkg::P_LATCH ##1 o_drv_off)
        else $error("zero delay latch not taken");
    a_latch_hold: assert property (q_ff.ps == bmoc_pkg::P_LATCH && en
        |=> q_ff.ps == bmoc_pkg::P_LATCH && o_drv_off)
        else $error("latch released while enabled");
    a_hiccup_end: assert property (q_ff.ps == bmoc_pkg::P_HICCUP && en
        && q_ff.cnt == 21'(HICCUP_CYC - 1) |=> q_ff.ps == bmoc_pkg::P_SS ##1 o_ss_run)
        else $error("hiccup restart missing");
    a_ss_no_uv: assert property (q_ff.ps == bmoc_pkg::P_SS
        |=> q_ff.ps != bmoc_pkg::P_LATCH && q_ff.ps != bmoc_pkg::P_HICCUP)
        else $error("undervoltage acted in soft-start");
    a_uv_flag: assert property (s_uv_now |=> q_ff.sv[bmoc_pkg::B_UVF])
        else $error("undervoltage flag not set");
    a_uv_timer: assert property (q_ff.ps == bmoc_pkg::P_RUN && !uv |=> q_ff.cnt == 21'h0)
        else $error("delay timer not cleared");
endmodule

//--- test_bmoc_top.sv
// file: self-checking bench for bmoc_top over its serial bus and stage pins
// assumes bmoc_pkg and bmoc_stage_model are compiled first; 25 MHz clock
`timescale 1ns/1ps
module test_bmoc_top;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic scl = 1'b1;
    logic sda_m = 1'b1;
    logic en = 1'b0;
    logic heavy = 1'b0;
    logic vlow = 1'b0;
    logic ss_done, uv, valley_current_limit, ls_on, sda_o, sda_oe, forced_continuous_mode, ls_hold, hs_block, drv_off, ss_run;
    logic [7:0] isense, avg;
    logic [10:0] fsw;
    logic [15:0] droop;
    bmoc_pkg::bmoc_comp_t comp;
    logic [7:0] ca [3] = '{8'hA9, 8'hAA, 8'hAD};
    logic [7:0] cv [3] = '{8'h5A, 8'h3C, 8'h03};
    int n_mismatch = 0;
    int comparisons = 0;
    // open-drain data line with pull-up
    wire sda = sda_m & ~sda_oe;
    always #20 i_clk = ~i_clk;
    bmoc_top #(.HICCUP_CYC(50)) uut (
        .i_clk(i_clk), .i_srst(i_srst), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
        .o_sda_oe(sda_oe), .i_en(en), .i_ss_done(ss_done), .i_uv_cmp(uv),
        .i_ocl_cmp(valley_current_limit), .i_ls_on(ls_on), .i_isense(isense), .o_fsw_khz(fsw),
        .o_forced_continuous_mode(forced_continuous_mode), .o_ls_hold(ls_hold), .o_hs_block(hs_block), .o_drv_off(drv_off),
        .o_ss_run(ss_run), .o_iout_avg(avg), .o_droop(droop), .o_comp(comp)
    );
    bmoc_stage_model stage (
        .i_clk(i_clk), .i_heavy(heavy), .i_vout_low(vlow), .i_drv_off(drv_off),
        .i_ss_run(ss_run), .i_ls_hold(ls_hold), .o_ss_done(ss_done), .o_uv_cmp(uv),
        .o_ocl_cmp(valley_current_limit), .o_ls_on(ls_on), .o_isense(isense)
    );
    // verdict and end of run
    task complete_run;
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task tk(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // bounded wait on drv_off (0), ss_run (1) or ls_hold (2)
    task wt(input int s, input logic v, input int lim);
        logic c;
        for (int i = 0; i <= lim; i++) begin
            c = (s == 0) ? drv_off : (s == 1) ? ss_run : ls_hold;
            if (c === v) break;
            tk(1);
        end
        chk("wait", c, v);
        if (c !== v) complete_run();
    endtask
    // one bus bit: data set while clock low, sampled at end of high phase
    task bt(input logic b, output logic r);
        sda_m = b;
        tk(6);
        scl = 1'b1;
        tk(6);
        r = sda;
        scl = 1'b0;
        tk(6);
    endtask
    task by(input logic [7:0] d, input logic ak, input logic ck, output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) bt(d[i], r[i]);
        bt(ak, a);
        if (ck) chk("ack", a, 1'b0);
    endtask
    task sst;
        sda_m = 1'b1;
        tk(3);
        scl = 1'b1;
        tk(6);
        sda_m = 1'b0;
        tk(6);
        scl = 1'b0;
        tk(6);
    endtask
    task stp;
        sda_m = 1'b0;
        tk(6);
        scl = 1'b1;
        tk(6);
        sda_m = 1'b1;
        tk(6);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        sst();
        by({bmoc_pkg::DEV_ADDR, 1'b0}, 1'b1, 1'b1, r);
        by(a, 1'b1, 1'b1, r);
        by(d, 1'b1, 1'b1, r);
        stp();
        tk(4);
    endtask
    task rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] r;
        logic [7:0] d;
        sst();
        by({bmoc_pkg::DEV_ADDR, 1'b0}, 1'b1, 1'b1, r);
        by(a, 1'b1, 1'b1, r);
        sst();
        by({bmoc_pkg::DEV_ADDR, 1'b1}, 1'b1, 1'b1, r);
        by(8'hFF, 1'b1, 1'b0, d);
        stp();
        chk("reg_read", d, e);
    endtask
    initial begin
        tk(10);
        i_srst = 1'b0;
        tk(3);
        // reset state, frequency decode and out-of-range code
        chk("fsw", fsw, 24'h000258);
        chk("drv_off", drv_off, 1'b1);
        chk("sda_o", sda_o, 1'b0);
        rc(8'h33, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(8'h33, 8'(k));
            chk("fsw", fsw, 24'(16'h0258 + 16'h00C8 * k));
        end
        wr(8'h33, 8'h04);
        chk("fsw", fsw, 24'h0004B0);
        rc(8'h33, 8'h03);
        // compensation fields from three registers
        for (int k = 0; k < 3; k++) wr(ca[k], cv[k]);
        chk("comp", comp, {cv[0], cv[1], cv[2]});
        for (int k = 0; k < 3; k++) rc(ca[k], cv[k]);
        // mode sampled at enable, frozen while enabled
        wr(8'hA0, 8'h01);
        en = 1'b1;
        wt(1, 1'b1, 10);
        chk("forced_continuous_mode", forced_continuous_mode, 1'b1);
        wr(8'hA0, 8'h00);
        rc(8'hA0, 8'h00);
        chk("forced_continuous_mode", forced_continuous_mode, 1'b1);
        // clamp during soft-start, low output ignored there
        vlow = 1'b1;
        heavy = 1'b1;
        wt(2, 1'b1, 8);
        chk("hs_block", hs_block, 1'b1);
        tk(100);
        chk("drv_off", drv_off, 1'b0);
        heavy = 1'b0;
        vlow = 1'b0;
        wt(2, 1'b0, 8);
        chk("hs_block", hs_block, 1'b0);
        rc(8'h7B, 8'h80);
        rc(8'h7B, 8'h00);
        // averaged current and droop in steady run
        wt(1, 1'b0, 4200);
        tk(60);
        chk("iout_avg", avg, 8'h3C);
        chk("droop", droop, 16'h00B4);
        wr(8'hAD, 8'h00);
        chk("droop", droop, 16'h0000);
        // short dip restarts the delay, then latch-off after the full delay
        wr(8'h45, 8'h01);
        vlow = 1'b1;
        tk(12);
        vlow = 1'b0;
        tk(10);
        vlow = 1'b1;
        tk(20);
        chk("drv_off", drv_off, 1'b0);
        wt(0, 1'b1, 15);
        vlow = 1'b0;
        tk(200);
        chk("drv_off", drv_off, 1'b1);
        chk("ss_run", ss_run, 1'b0);
        rc(8'h7A, 8'h10);
        en = 1'b0;
        tk(6);
        en = 1'b1;
        wt(1, 1'b1, 10);
        chk("forced_continuous_mode", forced_continuous_mode, 1'b0);
        // hiccup restart, then a second undervoltage shutdown
        wr(8'h45, 8'h09);
        wt(1, 1'b0, 4200);
        vlow = 1'b1;
        wt(0, 1'b1, 40);
        tk(40);
        chk("ss_run", ss_run, 1'b0);
        wt(1, 1'b1, 20);
        wt(0, 1'b0, 5);
        wt(0, 1'b1, 4300);
        vlow = 1'b0;
        // zero delay with restart bit clear latches at once, no hiccup retry
        wr(8'h45, 8'h00);
        wt(1, 1'b0, 4200);
        vlow = 1'b1;
        wt(0, 1'b1, 6);
        tk(70);
        chk("ss_run", ss_run, 1'b0);
        vlow = 1'b0;
        // unmapped address reads zero
        rc(8'h10, 8'h00);
        complete_run();
    end
endmodule
